/* logic/afc_pkg.sv */
// Purpose: Shared constants and types for the axis fault and completion check
// Assumes: One axis per instance, host values arrive as plain ports
// Notes: Error and warning numbers are kept as decimal codes in 16 bits
package afc_pkg;
    localparam int CODE_W = 16;
    localparam int PAR_W = 16;
    localparam int TIME_W = 16;
    localparam logic [CODE_W-1:0] CODE_NONE = 16'h0000;
    // Codes 938, 104, 105, 971, 997, 100 and 500
    localparam logic [CODE_W-1:0] ERR_BACKLASH = 16'h03AA;
    localparam logic [CODE_W-1:0] ERR_LIMIT_UP = 16'h0068;
    localparam logic [CODE_W-1:0] ERR_LIMIT_DN = 16'h0069;
    localparam logic [CODE_W-1:0] ERR_NEAR_PASS = 16'h03CB;
    localparam logic [CODE_W-1:0] ERR_SHIFT_SPD = 16'h03E5;
    localparam logic [CODE_W-1:0] WRN_START_BUSY = 16'h0064;
    localparam logic [CODE_W-1:0] WRN_DECEL_SPD = 16'h01F4;
    localparam logic [PAR_W-1:0] BACKLASH_MAX = 16'h00FF;
    localparam logic [PAR_W-1:0] SEL_MAX = 16'h0001;
    // Completion time unit: 1 ms at 25 MHz
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
    // Run state reported to the host
    localparam logic [2:0] RUN_IDLE = 3'h0;
    localparam logic [2:0] RUN_MOVE = 3'h1;
    localparam logic [2:0] RUN_DECEL = 3'h2;
    localparam logic [2:0] RUN_STOPPED = 3'h3;
    localparam logic [2:0] RUN_ERROR = 3'h4;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_MOVE = 4'b0010,
        ST_DECEL = 4'b0100,
        ST_DONE = 4'b1000
    } afc_state_t;
endpackage : afc_pkg

/* logic/afc_param_if.sv */
// Purpose: Carries parameter check results between the checker and the top
// Assumes: Single clock domain
// Notes: Plain wires, no clocking
`timescale 1ns/1ps
interface afc_param_if;
    logic backlash_bad;
    logic near_pass_bad;
    logic shift_speed_bad;
    modport chk (output backlash_bad, output near_pass_bad,
        output shift_speed_bad);
    modport top (input backlash_bad, input near_pass_bad,
        input shift_speed_bad);
endinterface : afc_param_if

/* logic/afc_param_chk.sv */
// Purpose: Registered validity checks on host parameter values
// Assumes: Parameters are stable for a cycle before use
// Notes: Division is avoided by comparing against 255 times pulse step
`timescale 1ns/1ps
module afc_param_chk
    import afc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [PAR_W-1:0] backlash_i,
    input wire logic [PAR_W-1:0] move_per_pulse_i,
    input wire logic [PAR_W-1:0] near_pass_select_i,
    input wire logic [PAR_W-1:0] shift_speed_select_i,
    afc_param_if.chk res
);
    logic [2:0] bad_d;
    logic [2:0] bad_q;
    logic [2*PAR_W-1:0] lim;

    // Negative ratio impossible, unsigned; zero step treated as invalid
    always_comb begin
        lim = (2*PAR_W)'(move_per_pulse_i) * (2*PAR_W)'(BACKLASH_MAX);
        bad_d[0] = (move_per_pulse_i == '0) ||
            ({{PAR_W{1'b0}}, backlash_i} > lim);
        bad_d[1] = near_pass_select_i > SEL_MAX;
        bad_d[2] = shift_speed_select_i > SEL_MAX;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bad_q <= 3'h0;
        end else begin
            bad_q <= bad_d;
        end
    end

    assign res.backlash_bad = bad_q[0];
    assign res.near_pass_bad = bad_q[1];
    assign res.shift_speed_bad = bad_q[2];
endmodule : afc_param_chk

/* logic/afc_axis_check.sv */
// Purpose: Per-axis error, warning and completion signalling
// Assumes: Host inputs are synchronous; motion engine reports events
// Notes: Error code holds until error_reset_i
//
// What this block does
// - Error 938 when backlash ratio exceeds 255
// - Jog into active stroke limit: 104/105
// - Error 971 when near-pass select not 0/1
// - Error 997 on host ready rise, bad select
// - Stop signal starts deceleration, axis stays busy
// - Start while busy ignored, warning 100
// - Warning 500 only while decelerating, nonhalting
// - Override speed applies from next start
// - Stop during positioning suppresses completion pulse
// - Error withholds completion, records error code
`timescale 1ns/1ps
module afc_axis_check
    import afc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Host parameters
    input wire logic [PAR_W-1:0] backlash_i,
    input wire logic [PAR_W-1:0] move_per_pulse_i,
    input wire logic [PAR_W-1:0] near_pass_select_i,
    input wire logic [PAR_W-1:0] shift_speed_select_i,
    input wire logic [PAR_W-1:0] override_speed_i,
    input wire logic [TIME_W-1:0] complete_time_i,
    // Host control
    input wire logic host_ready_i,
    input wire logic start_i,
    input wire logic jog_i,
    input wire logic host_stop_i,
    input wire logic error_reset_i,
    input wire logic speed_change_i,
    // Machine side
    input wire logic ext_stop_i,
    input wire logic limit_up_i,
    input wire logic limit_dn_i,
    // Motion engine events
    input wire logic move_done_i,
    input wire logic decel_done_i,
    input wire logic auto_decel_i,
    input wire logic motion_fault_i,
    input wire logic [CODE_W-1:0] motion_fault_code_i,
    // Status
    output logic busy_o,
    output logic run_o,
    output logic decel_o,
    output logic [PAR_W-1:0] active_speed_o,
    output logic complete_o,
    output logic [CODE_W-1:0] axis_error_code_o,
    output logic [CODE_W-1:0] axis_warning_code_o,
    output logic [2:0] axis_run_state_o
);
    afc_param_if chk_if ();

    afc_param_chk u_chk (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .backlash_i(backlash_i),
        .move_per_pulse_i(move_per_pulse_i),
        .near_pass_select_i(near_pass_select_i),
        .shift_speed_select_i(shift_speed_select_i),
        .res(chk_if)
    );

    afc_state_t st_q, st_d;
    logic ready_q, ready_d;
    logic stop_q, stop_d;
    logic err_flag_q, err_flag_d;
    logic stopped_q, stopped_d;
    logic [CODE_W-1:0] err_q, err_d;
    logic [CODE_W-1:0] wrn_q, wrn_d;
    logic [PAR_W-1:0] spd_q, spd_d;
    logic [2:0] rs_q, rs_d;
    logic cmp_q, cmp_d;
    logic [TIME_W-1:0] cmp_left_q, cmp_left_d;
    logic [31:0] tick_q, tick_d;
    logic any_stop, stop_rise, busy, err_now;
    logic cmp_start, ms_tick, busy_d, run_d, decel_d;
    logic [CODE_W-1:0] err_code;

    // Error source with fixed priority; first one found wins
    function automatic logic [CODE_W-1:0] pick_err(
        input logic bl, input logic np, input logic ss, input logic mf,
        input logic [CODE_W-1:0] mcode);
        logic [CODE_W-1:0] c;
        c = CODE_NONE;
        if (mf) begin
            c = mcode;
        end else if (ss) begin
            c = ERR_SHIFT_SPD;
        end else if (np) begin
            c = ERR_NEAR_PASS;
        end else if (bl) begin
            c = ERR_BACKLASH;
        end
        return c;
    endfunction : pick_err

    // Positioning counts as busy through the deceleration stop
    function automatic logic is_busy(input afc_state_t s);
        return (s == ST_MOVE) || (s == ST_DECEL);
    endfunction : is_busy

    always_comb begin
        any_stop = host_stop_i | ext_stop_i;
        stop_rise = any_stop & ~stop_q;
        busy = is_busy(st_q);
        err_code = pick_err(chk_if.backlash_bad, chk_if.near_pass_bad,
            chk_if.shift_speed_bad & host_ready_i & ~ready_q,
            motion_fault_i & busy, motion_fault_code_i);
        err_now = (err_code != CODE_NONE);
    end

    // Axis sequencing
    always_comb begin
        st_d = st_q;
        ready_d = host_ready_i;
        stop_d = any_stop;
        err_flag_d = err_flag_q;
        stopped_d = stopped_q;
        err_d = err_q;
        wrn_d = wrn_q;
        spd_d = spd_q;
        rs_d = rs_q;
        // Clear first, so an error in the same cycle still lands
        if (error_reset_i) begin
            err_d = CODE_NONE;
            wrn_d = CODE_NONE;
            err_flag_d = 1'b0;
        end
        if (err_now) begin
            err_d = err_code;
            err_flag_d = 1'b1;
        end
        // Warning 500 is advisory: motion proceeds, code just sticks
        if (speed_change_i && (st_q == ST_DECEL || auto_decel_i)) begin
            wrn_d = WRN_DECEL_SPD;
        end
        case (st_q)
            ST_IDLE, ST_DONE: begin
                if (start_i || jog_i) begin
                    if (jog_i && limit_up_i) begin
                        err_d = ERR_LIMIT_UP;
                        err_flag_d = 1'b1;
                        rs_d = RUN_ERROR;
                    end else if (jog_i && limit_dn_i) begin
                        err_d = ERR_LIMIT_DN;
                        err_flag_d = 1'b1;
                        rs_d = RUN_ERROR;
                    end else if (!err_flag_q && !err_now && host_ready_i) begin
                        // Override latched only here, not mid-move
                        spd_d = override_speed_i;
                        stopped_d = 1'b0;
                        rs_d = RUN_MOVE;
                        st_d = ST_MOVE;
                    end
                end
            end
            ST_MOVE: begin
                if (start_i || jog_i) begin
                    wrn_d = WRN_START_BUSY;
                end
                if (err_now || stop_rise) begin
                    stopped_d = 1'b1;
                    rs_d = RUN_DECEL;
                    st_d = ST_DECEL;
                end else if (move_done_i) begin
                    rs_d = RUN_IDLE;
                    st_d = ST_DONE;
                end
            end
            ST_DECEL: begin
                if (start_i || jog_i) begin
                    wrn_d = WRN_START_BUSY;
                end
                if (decel_done_i) begin
                    rs_d = err_flag_d ? RUN_ERROR : RUN_STOPPED;
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
                rs_d = RUN_IDLE;
            end
        endcase
    end

    // Qualified here so a stop or error in the same cycle wins
    always_comb begin
        cmp_start = (st_q == ST_MOVE) && move_done_i && !err_now &&
            !stop_rise && !stopped_q;
    end

    // Millisecond enable, restarted per pulse so the first one is whole
    always_comb begin
        tick_d = tick_q;
        ms_tick = 1'b0;
        if (cmp_start || !cmp_q) begin
            tick_d = 32'(TICK_CYCLES - 1);
        end else if (tick_q == '0) begin
            ms_tick = 1'b1;
            tick_d = 32'(TICK_CYCLES - 1);
        end else begin
            tick_d = tick_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_d;
        end
    end

    // Completion pulse length in milliseconds
    always_comb begin
        cmp_d = cmp_q;
        cmp_left_d = cmp_left_q;
        if (cmp_start) begin
            cmp_d = (complete_time_i != '0);
            cmp_left_d = complete_time_i;
        end else if (cmp_q) begin
            // Any new start or jog ends the pulse early
            if ((start_i || jog_i) && !busy) begin
                cmp_d = 1'b0;
            end else if (ms_tick) begin
                cmp_left_d = cmp_left_q - 1'b1;
                if (cmp_left_q == 16'h0001) begin
                    cmp_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            ready_q <= 1'b0;
            stop_q <= 1'b0;
            err_flag_q <= 1'b0;
            stopped_q <= 1'b0;
            err_q <= CODE_NONE;
            wrn_q <= CODE_NONE;
            spd_q <= '0;
            rs_q <= RUN_IDLE;
            cmp_q <= 1'b0;
            cmp_left_q <= '0;
        end else begin
            st_q <= st_d;
            ready_q <= ready_d;
            stop_q <= stop_d;
            err_flag_q <= err_flag_d;
            stopped_q <= stopped_d;
            err_q <= err_d;
            wrn_q <= wrn_d;
            spd_q <= spd_d;
            rs_q <= rs_d;
            cmp_q <= cmp_d;
            cmp_left_q <= cmp_left_d;
        end
    end

    // Flags follow the next state so they line up with it
    always_comb begin
        busy_d = is_busy(st_d);
        run_d = (st_d == ST_MOVE);
        decel_d = (st_d == ST_DECEL);
    end

    // Status outputs come straight from flip-flops
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            run_o <= 1'b0;
            decel_o <= 1'b0;
            active_speed_o <= '0;
            complete_o <= 1'b0;
            axis_error_code_o <= CODE_NONE;
            axis_warning_code_o <= CODE_NONE;
            axis_run_state_o <= RUN_IDLE;
        end else begin
            busy_o <= busy_d;
            run_o <= run_d;
            decel_o <= decel_d;
            active_speed_o <= spd_d;
            complete_o <= cmp_d;
            axis_error_code_o <= err_d;
            axis_warning_code_o <= wrn_d;
            axis_run_state_o <= rs_d;
        end
    end
endmodule : afc_axis_check

/* bench/afc_axis_check_sva.sv */
// Purpose: Port checks for the axis fault and completion logic
// Assumes: One clock, reset active high
// Notes: Pulse width is counted, too long to unroll
`timescale 1ns/1ps
module afc_axis_check_sva
    import afc_pkg::*;
#(
    parameter int TICK_CYCLES = 4
) (
    // Clock, reset, host, machine and engine inputs
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [PAR_W-1:0] near_pass_select_i,
    input wire logic [PAR_W-1:0] shift_speed_select_i,
    input wire logic [TIME_W-1:0] complete_time_i,
    input wire logic host_ready_i,
    input wire logic start_i,
    input wire logic jog_i,
    input wire logic host_stop_i,
    input wire logic speed_change_i,
    input wire logic limit_up_i,
    input wire logic move_done_i,
    input wire logic decel_done_i,
    input wire logic motion_fault_i,
    input wire logic [CODE_W-1:0] motion_fault_code_i,
    // Status
    input wire logic busy_o,
    input wire logic run_o,
    input wire logic decel_o,
    input wire logic complete_o,
    input wire logic [CODE_W-1:0] axis_error_code_o,
    input wire logic [CODE_W-1:0] axis_warning_code_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    always_comb cnt_d = complete_o ? cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i)
            cnt_q <= 32'h0;
        else
            cnt_q <= cnt_d;
    end
    property p_lim;
        jog_i && limit_up_i && !busy_o && host_ready_i && !motion_fault_i
        && axis_error_code_o == CODE_NONE |=>
        axis_error_code_o == ERR_LIMIT_UP && !busy_o;
    endproperty
    a_lim: assert property (p_lim) else $error("limit");
    property p_np;
        (near_pass_select_i > SEL_MAX && !motion_fault_i)[*2] |=>
        axis_error_code_o == ERR_NEAR_PASS;
    endproperty
    a_np: assert property (p_np) else $error("near pass");
    property p_ss;
        $rose(host_ready_i) && shift_speed_select_i > SEL_MAX &&
        !motion_fault_i |-> ##[1:2] axis_error_code_o == ERR_SHIFT_SPD;
    endproperty
    a_ss: assert property (p_ss) else $error("shift");
    property p_stop;
        run_o && $rose(host_stop_i) && !move_done_i |=> decel_o && busy_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop");
    property p_busy;
        busy_o && start_i && !move_done_i && !decel_done_i &&
        !speed_change_i |=> axis_warning_code_o == WRN_START_BUSY;
    endproperty
    a_busy: assert property (p_busy) else $error("busy");
    property p_w5;
        decel_o && speed_change_i && !start_i && !decel_done_i |=>
        axis_warning_code_o == WRN_DECEL_SPD && busy_o;
    endproperty
    a_w5: assert property (p_w5) else $error("decel warn");
    property p_flt;
        run_o && motion_fault_i |=>
        axis_error_code_o == $past(motion_fault_code_i) && !complete_o;
    endproperty
    a_flt: assert property (p_flt) else $error("fault");
    property p_len;
        $fell(complete_o) && !$past(start_i) && !$past(jog_i) |->
        cnt_q == complete_time_i * TICK_CYCLES;
    endproperty
    a_len: assert property (p_len) else $error("pulse");
endmodule : afc_axis_check_sva

/* bench/afc_motion_model.sv */
// Purpose: Motion engine stand-in that ends moves and stops
// Assumes: Delay set by the bench, long delay stalls
// Notes: Counter keeps running across a stop
`timescale 1ns/1ps
module afc_motion_model (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic decel_i,
    input wire logic [7:0] dly_i,
    output logic move_done_o,
    output logic decel_done_o
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic fire;
    always_comb begin
        fire = (run_i || decel_i) && cnt_q == dly_i;
        cnt_d = ((run_i || decel_i) && !fire) ? cnt_q + 8'h01 : 8'h00;
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
            move_done_o <= 1'b0;
            decel_done_o <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            move_done_o <= fire && run_i;
            decel_done_o <= fire && decel_i && !run_i;
        end
    end
endmodule : afc_motion_model

/* bench/afc_axis_check_tb.sv */
// Purpose: Scenario bench for the axis fault and completion logic
// Assumes: Tick shortened to 4 clocks
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module afc_axis_check_tb;
    import afc_pkg::*;
    localparam int TICK_CYCLES = 4;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [PAR_W-1:0] backlash_i = 16'h0000, move_per_pulse_i = 16'h0001;
    logic [PAR_W-1:0] near_pass_select_i = 16'h0000;
    logic [PAR_W-1:0] shift_speed_select_i = 16'h0000;
    logic [PAR_W-1:0] override_speed_i = 16'h0064;
    logic [TIME_W-1:0] complete_time_i = 16'h0002;
    logic host_ready_i = 1'b1, start_i = 1'b0, jog_i = 1'b0;
    logic host_stop_i = 1'b0, error_reset_i = 1'b0, speed_change_i = 1'b0;
    logic ext_stop_i = 1'b0, limit_up_i = 1'b0, limit_dn_i = 1'b0;
    logic auto_decel_i = 1'b0, motion_fault_i = 1'b0;
    logic [CODE_W-1:0] motion_fault_code_i = 16'h0000;
    logic move_done_i, decel_done_i, busy_o, run_o, decel_o, complete_o;
    logic [PAR_W-1:0] active_speed_o;
    logic [CODE_W-1:0] axis_error_code_o, axis_warning_code_o;
    logic [2:0] axis_run_state_o;
    logic [7:0] dly = 8'h0A;
    int n_mismatch = 0;
    int check_count = 0;
    always #20 core_clk_i = ~core_clk_i;
    afc_axis_check #(.TICK_CYCLES(TICK_CYCLES)) dut_u (.*);
    afc_motion_model eng_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .run_i(run_o), .decel_i(decel_o), .dly_i(dly),
        .move_done_o(move_done_i), .decel_done_o(decel_done_i));
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : step
    function automatic logic [15:0] fx(input logic b);
        return {13'h0000, 2'b00, b};
    endfunction : fx
    task automatic chk(input string nm, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic go(input logic j);
        jog_i = j;
        start_i = !j;
        step(1);
        jog_i = 1'b0;
        start_i = 1'b0;
    endtask : go
    task automatic clr();
        step(2);
        error_reset_i = 1'b1;
        step(1);
        error_reset_i = 1'b0;
        step(3);
    endtask : clr
    task automatic wait_idle();
        for (int i = 0; i < 300 && busy_o === 1'b1; i++) begin
            step(1);
        end
        chk("idle", 16'h0000, fx(busy_o));
    endtask : wait_idle
    task automatic t_normal();
        int n;
        n = 0;
        go(1'b0);
        chk("busy", 16'h0001, fx(busy_o));
        override_speed_i = 16'h00C8;
        speed_change_i = 1'b1;
        step(1);
        speed_change_i = 1'b0;
        chk("speed", 16'h0064, active_speed_o);
        wait_idle();
        while (complete_o === 1'b1 && n < 100) begin
            n++;
            step(1);
        end
        chk("pulse", 16'(TICK_CYCLES * 2), n[15:0]);
        go(1'b0);
        chk("speed", 16'h00C8, active_speed_o);
        wait_idle();
        step(12);
    endtask : t_normal
    task automatic t_stop();
        dly = 8'h28;
        go(1'b0);
        step(2);
        host_stop_i = 1'b1;
        step(1);
        chk("decel", 16'h0001, fx(decel_o));
        go(1'b0);
        chk("warn", WRN_START_BUSY, axis_warning_code_o);
        speed_change_i = 1'b1;
        step(1);
        speed_change_i = 1'b0;
        chk("warn", WRN_DECEL_SPD, axis_warning_code_o);
        chk("busy", 16'h0001, fx(busy_o));
        host_stop_i = 1'b0;
        wait_idle();
        chk("done", 16'h0000, fx(complete_o));
        chk("state", 16'(RUN_STOPPED), 16'(axis_run_state_o));
    endtask : t_stop
    task automatic t_fault();
        dly = 8'h14;
        go(1'b0);
        step(2);
        motion_fault_code_i = 16'h0141;
        motion_fault_i = 1'b1;
        step(1);
        motion_fault_i = 1'b0;
        chk("err", 16'h0141, axis_error_code_o);
        wait_idle();
        chk("done", 16'h0000, fx(complete_o));
        chk("state", 16'(RUN_ERROR), 16'(axis_run_state_o));
        clr();
    endtask : t_fault
    task automatic t_limit();
        limit_up_i = 1'b1;
        go(1'b1);
        chk("err", ERR_LIMIT_UP, axis_error_code_o);
        clr();
        limit_up_i = 1'b0;
        limit_dn_i = 1'b1;
        go(1'b1);
        chk("err", ERR_LIMIT_DN, axis_error_code_o);
        chk("busy", 16'h0000, fx(busy_o));
        limit_dn_i = 1'b0;
        clr();
    endtask : t_limit
    task automatic t_ext();
        go(1'b0);
        auto_decel_i = 1'b1;
        speed_change_i = 1'b1;
        step(1);
        auto_decel_i = 1'b0;
        speed_change_i = 1'b0;
        chk("warn", WRN_DECEL_SPD, axis_warning_code_o);
        chk("busy", 16'h0001, fx(busy_o));
        ext_stop_i = 1'b1;
        step(1);
        chk("decel", 16'h0001, fx(decel_o));
        ext_stop_i = 1'b0;
        wait_idle();
        chk("done", 16'h0000, fx(complete_o));
    endtask : t_ext
    task automatic t_param();
        near_pass_select_i = 16'h0002;
        step(3);
        chk("err", ERR_NEAR_PASS, axis_error_code_o);
        near_pass_select_i = 16'h0000;
        move_per_pulse_i = 16'h0000;
        clr();
        chk("err", ERR_BACKLASH, axis_error_code_o);
        move_per_pulse_i = 16'h0001;
        backlash_i = 16'h0100;
        clr();
        chk("err", ERR_BACKLASH, axis_error_code_o);
        backlash_i = 16'h00FF;
        clr();
        chk("err", CODE_NONE, axis_error_code_o);
        shift_speed_select_i = 16'h0002;
        host_ready_i = 1'b0;
        step(2);
        host_ready_i = 1'b1;
        step(3);
        chk("err", ERR_SHIFT_SPD, axis_error_code_o);
    endtask : t_param
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        step(16);
        rst_i = 1'b0;
        step(2);
        t_normal();
        t_stop();
        t_fault();
        t_limit();
        t_ext();
        t_param();
        final_report();
    end
    initial begin
        #400000;
        n_mismatch++;
        final_report();
    end
endmodule : afc_axis_check_tb
bind afc_axis_check afc_axis_check_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_u (.*);
